// ---- tb/qcr_core_checker.sv ----
// assertions on the quad read core ports
`timescale 1ns/10ps
module qcr_core_checker
    import qcr_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic CS_N_I,
    input wire logic [3:0] IO_O,
    input wire logic [3:0] IO_OE_O,
    input wire logic CONTINUOUS_READ_MODE_O,
    input wire logic [QCR_MEM_AW-1:0] MEM_ADDR_O,
    input wire logic MEM_RD_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    logic [QCR_MEM_AW-1:0] prev_r;
    always_ff @(posedge CORE_CLK_I) begin
        prev_r <= MEM_RD_O ? MEM_ADDR_O : prev_r;
    end
    oe_all_lanes_a: assert property (IO_OE_O == 4'h0 || IO_OE_O == 4'hf) else $error("lanes split");
    cs_release_a: assert property (CS_N_I [*8] |-> IO_OE_O == 4'h0) else $error("driven, cs high");
    cs_no_read_a: assert property (CS_N_I [*8] |-> !MEM_RD_O) else $error("read, cs high");
    rd_spacing_a: assert property (MEM_RD_O |=> !MEM_RD_O [*5]) else $error("reads too close");
    addr_step_a: assert property (MEM_RD_O && IO_OE_O == 4'hf && $past(IO_OE_O) == 4'hf
        |-> MEM_ADDR_O == prev_r + QCR_MEM_AW'(1'b1)) else $error("address not sequential");
    nib_hold_a: assert property ($changed(IO_O) && IO_OE_O == 4'hf |=> $stable(IO_O) [*3])
        else $error("nibble too short");
    cont_hold_a: assert property (CS_N_I [*8] |=> $stable(CONTINUOUS_READ_MODE_O))
        else $error("mode moved, cs high");
    oe_in_frame_a: assert property ($rose(IO_OE_O[0]) |-> !CS_N_I && !$past(CS_N_I, 2))
        else $error("drive outside frame");
    cover property ($rose(CONTINUOUS_READ_MODE_O));
    cover property ($fell(CONTINUOUS_READ_MODE_O));
    cover property ($rose(IO_OE_O[0]));
endmodule
bind qcr_core qcr_core_checker chk_i (.CORE_CLK_I, .SYS_RST_I, .CS_N_I, .IO_O, .IO_OE_O,
    .CONTINUOUS_READ_MODE_O, .MEM_ADDR_O, .MEM_RD_O);

// ---- tb/qcr_core_tb_top.sv ----
// testbench for the quad read core
`timescale 1ns/10ps
module qcr_core_tb_top
    import qcr_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] dc = 3'h0;
    logic al = 1'b0;
    logic [7:0] mem_data;
    logic [15:0] seed = 16'h4386;
    logic [3:0] io_o, io_oe, host_io, io_w;
    logic sck, cs_n, host_oe, cont, mem_rd;
    logic [QCR_MEM_AW-1:0] mem_addr;
    logic kind_al = 1'b0;
    logic ec = 1'b0;
    logic oe_seen = 1'b0;
    int n_fail = 0;
    int total_checks = 0;
    initial forever #5 clk = ~clk;
    assign io_w = io_oe[0] ? io_o : (host_oe ? host_io : ~host_io);
    qcr_host host (.io_i(io_w), .sck_o(sck), .cs_n_o(cs_n), .io_o(host_io), .io_oe_o(host_oe));
    qcr_core dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .SCK_I(sck), .CS_N_I(cs_n), .IO_I(io_w), .IO_O(io_o),
        .IO_OE_O(io_oe), .DUMMY_CYCLE_COUNT_I(dc), .ALIGNED_ADDRESS_SELECT_I(al),
        .CONTINUOUS_READ_MODE_O(cont), .MEM_ADDR_O(mem_addr), .MEM_RD_O(mem_rd), .MEM_DATA_I(mem_data));
    function automatic logic [7:0] mem_byte(input logic [20:0] a);
        return a[7:0] ^ a[15:8] ^ {3'h0, a[20:16]};
    endfunction
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // array answers in the strobe cycle; off the strobe it shows wrong data on purpose
    assign mem_data = mem_rd ? mem_byte(mem_addr) : ~mem_byte(mem_addr);
    always @(posedge clk) begin
        if (io_oe[0] === 1'b1) oe_seen = 1'b1;
    end
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic run(input bit op_en, input logic [7:0] op, input logic [23:0] a, input logic [7:0] m,
        input logic [2:0] c, input logic s, input int nnib);
        logic [20:0] st;
        logic good;
        @(posedge clk);
        dc <= c;
        al <= s;
        oe_seen = 1'b0;
        good = op_en ? (op == QCR_OP_QUAD || op == QCR_OP_ALIGNED) : ec;
        if (op_en && good) kind_al = (op == QCR_OP_ALIGNED);
        st = a[20:0] & ((kind_al | s) ? 21'h1ffffc : 21'h1fffff);
        host.xfer(op_en, op, a, m, 2 + 2 * (c > 3'h4 ? 4 : int'(c)), nnib);
        for (int k = 0; k < nnib / 2 && good; k++) chk("byte", {host.got[2*k], host.got[2*k+1]}, mem_byte(st + 21'(k)));
        chk("drive", oe_seen, good);
        chk("release", io_oe, 4'h0);
        if (good) ec = ((m & 8'h30) == 8'h20);
        chk("cont", cont, ec);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        run(1'b1, QCR_OP_QUAD, {seed, 8'h5a}, 8'h20, 3'h0, 1'b0, 6);
        run(1'b0, 8'h00, {8'h00, lfsr(seed)}, 8'h25, 3'h7, 1'b0, 5);
        run(1'b0, 8'h00, 24'h0abcd7, 8'hff, 3'h2, 1'b1, 4);
        run(1'b1, QCR_OP_ALIGNED, 24'h123457, 8'h00, 3'h1, 1'b0, 4);
        run(1'b1, QCR_OP_QUAD, 24'hffffff, 8'h00, 3'h0, 1'b0, 6);
        run(1'b1, 8'h03, 24'h000000, 8'h20, 3'h0, 1'b0, 2);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(lfsr(seed));
            run(~ec, seed[1] ? QCR_OP_ALIGNED : QCR_OP_QUAD, {seed[7:0], lfsr(seed)}, seed[15:8],
                seed[4:2], seed[5], 4);
        end
        results();
    end
    initial begin
        #300000;
        n_fail++;
        results();
    end
endmodule

// ---- tb/qcr_host.sv ----
// host controller model driving the serial link
`timescale 1ns/10ps
module qcr_host (
    input wire logic [3:0] io_i,
    output logic sck_o,
    output logic cs_n_o,
    output logic [3:0] io_o,
    output logic io_oe_o
);
    logic [3:0] got [0:15];
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        io_o = 4'h0;
        io_oe_o = 1'b0;
    end
    task automatic clk_out(input logic [3:0] v);
        io_o = v;
        io_oe_o = 1'b1;
        #40 sck_o = 1'b1;
        #40 sck_o = 1'b0;
    endtask
    task automatic xfer(input bit op_en, input logic [7:0] op, input logic [23:0] a, input logic [7:0] m,
        input int ndum, input int nnib);
        // keep pin changes off the core clock's sampling edge
        #2;
        cs_n_o = 1'b0;
        #40;
        for (int i = 7; i >= 0 && op_en; i--) clk_out({3'h0, op[i]});
        for (int i = 5; i >= 0; i--) clk_out(a[i*4 +: 4]);
        clk_out(m[7:4]);
        clk_out(m[3:0]);
        for (int i = 2; i < ndum; i++) clk_out(4'h0);
        io_oe_o = 1'b0;
        for (int i = 0; i < nnib; i++) begin
            #40 sck_o = 1'b1;
            #35 got[i] = io_i;
            #5 if (i < nnib - 1) sck_o = 1'b0;
        end
        cs_n_o = 1'b1;
        #40 sck_o = 1'b0;
        #160;
    endtask
endmodule

// ---- verilog/qcr_core.sv ----
// device side of the quad i/o read commands with continuous read mode
`timescale 1ns/10ps
module qcr_core
    import qcr_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic SCK_I,
    input wire logic CS_N_I,
    input wire logic [3:0] IO_I,
    output logic [3:0] IO_O,
    output logic [3:0] IO_OE_O,
    input wire logic [2:0] DUMMY_CYCLE_COUNT_I,
    input wire logic ALIGNED_ADDRESS_SELECT_I,
    output logic CONTINUOUS_READ_MODE_O,
    output logic [QCR_MEM_AW-1:0] MEM_ADDR_O,
    output logic MEM_RD_O,
    input wire logic [7:0] MEM_DATA_I
);
    qcr_pins_t pin;
    qcr_core_st_t r_r;
    qcr_core_st_t r_nxt;
    logic sck_rise;
    logic sck_fall;
    logic force_align;
    logic [23:0] addr_in;
    logic [7:0] mode_in;
    logic [2:0] dc_sel;
    logic [QCR_MEM_AW-1:0] addr_inc;
    // decodes shared by the phase logic
    logic [7:0] opcode_in;
    logic [3:0] cnt_inc;
    logic [3:0] dummy_total_in;
    logic addr_last;
    logic mode_last;
    logic dummy_last;

    // every link pin, the serial clock too, crosses domains here
    qcr_sync #(
        .WIDTH(6),
        .RST_VAL(QCR_PIN_RST)
    ) u_sync (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .async_i({CS_N_I, SCK_I, IO_I}),
        .level_o(pin)
    );

    assign sck_rise = pin.sck & ~r_r.sck_q;
    assign sck_fall = ~pin.sck & r_r.sck_q;

    assign force_align = r_r.aligned_cmd | ALIGNED_ADDRESS_SELECT_I;

    always_comb begin
        r_nxt = r_r;
        // step and end-of-phase decodes
        cnt_inc = r_r.cnt + 4'h1;
        addr_last = r_r.cnt == QCR_ADDR_LAST;
        mode_last = r_r.cnt == QCR_MODE_LAST;
        dummy_last = r_r.cnt == r_r.dummy_total - 4'h1;
        // next opcode value with io0 shifted in
        opcode_in = {r_r.opcode[6:0], pin.io[0]};
        // four address bits per clock, io3 highest
        addr_in = {r_r.addr[19:0], pin.io};
        // only the final nibble carries bits 1:0, so only it is masked
        if (force_align && addr_last) begin
            addr_in[1:0] = 2'b00;
        end
        mode_in = {r_r.mode[3:0], pin.io};
        // out-of-range codes hold at the longest setting
        dc_sel = (DUMMY_CYCLE_COUNT_I > QCR_DC_MAX) ? QCR_DC_MAX : DUMMY_CYCLE_COUNT_I;
        // total includes the two mode clocks
        dummy_total_in = QCR_DUMMY_BASE + {dc_sel, 1'b0};
        // address wraps at the top of the array
        addr_inc = r_r.addr[QCR_MEM_AW-1:0] + QCR_MEM_AW'(1'b1);
        r_nxt.sck_q = pin.sck;
        r_nxt.mem_rd = 1'b0;
        // array data must stand in the cycle the read strobe is high
        if (r_r.mem_rd) begin
            r_nxt.next_byte = MEM_DATA_I;
        end
        if (pin.cs_n) begin
            // chip select high aborts at once
            r_nxt.st = QCR_ST_IDLE;
            r_nxt.io_oe = 4'h0;
            r_nxt.cnt = QCR_CNT_RST;
            // a byte cut short leaves no half nibble for the next frame
            r_nxt.hi = 1'b1;
        end else begin
            unique case (r_r.st)
                QCR_ST_IDLE: begin
                    r_nxt.cnt = QCR_CNT_RST;
                    r_nxt.st = r_r.cont ? QCR_ST_ADDR : QCR_ST_OPCODE;
                end
                QCR_ST_OPCODE: begin
                    if (sck_rise) begin
                        r_nxt.opcode = opcode_in;
                        r_nxt.cnt = cnt_inc;
                        if (r_r.cnt == QCR_OPCODE_LAST) begin
                            r_nxt.cnt = QCR_CNT_RST;
                            if (opcode_in == QCR_OP_QUAD) begin
                                r_nxt.aligned_cmd = 1'b0;
                                r_nxt.st = QCR_ST_ADDR;
                            end else if (opcode_in == QCR_OP_ALIGNED) begin
                                r_nxt.aligned_cmd = 1'b1;
                                r_nxt.st = QCR_ST_ADDR;
                            end else begin
                                r_nxt.st = QCR_ST_IGNORE;
                            end
                        end
                    end
                end
                QCR_ST_ADDR: begin
                    if (sck_rise) begin
                        r_nxt.addr = addr_in;
                        r_nxt.cnt = cnt_inc;
                        if (addr_last) begin
                            r_nxt.cnt = QCR_CNT_RST;
                            r_nxt.mem_addr = addr_in[QCR_MEM_AW-1:0];
                            r_nxt.mem_rd = 1'b1;
                            // dummy total fixed for this frame
                            r_nxt.dummy_total = dummy_total_in;
                            r_nxt.st = QCR_ST_DUMMY;
                        end
                    end
                end
                QCR_ST_DUMMY: begin
                    if (sck_rise) begin
                        r_nxt.cnt = cnt_inc;
                        // mode field in the first two dummy clocks
                        if (r_r.cnt <= QCR_MODE_LAST) begin
                            r_nxt.mode = mode_in;
                        end
                        // mode decode enters or leaves continuous read
                        if (mode_last) begin
                            r_nxt.cont = (mode_in & QCR_MODE_CONT_MASK) == QCR_MODE_CONT_VAL;
                        end
                        if (dummy_last) begin
                            r_nxt.hi = 1'b1;
                            r_nxt.st = QCR_ST_DATA;
                        end
                    end
                end
                QCR_ST_DATA: begin
                    if (sck_fall) begin
                        // lines become outputs after the dummy phase
                        r_nxt.io_oe = 4'hf;
                        if (r_r.hi) begin
                            // high nibble first, bit 7 on io3
                            r_nxt.io_o = r_r.next_byte[7:4];
                            r_nxt.low_nib = r_r.next_byte[3:0];
                            r_nxt.hi = 1'b0;
                            // fetch the following byte, wrapping to zero
                            r_nxt.addr = {3'b000, addr_inc};
                            r_nxt.mem_addr = addr_inc;
                            r_nxt.mem_rd = 1'b1;
                        end else begin
                            r_nxt.io_o = r_r.low_nib;
                            r_nxt.hi = 1'b1;
                        end
                    end
                end
                QCR_ST_IGNORE: begin
                    // unknown opcode: lines stay inputs until chip select rises
                    r_nxt.io_oe = 4'h0;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            r_r.st <= QCR_ST_IDLE;
            r_r.sck_q <= 1'b0;
            r_r.cnt <= QCR_CNT_RST;
            r_r.dummy_total <= QCR_DUMMY_BASE;
            r_r.opcode <= QCR_BYTE_RST;
            r_r.aligned_cmd <= 1'b0;
            r_r.addr <= QCR_ADDR_RST;
            r_r.mode <= QCR_BYTE_RST;
            r_r.cont <= 1'b0;
            r_r.next_byte <= QCR_BYTE_RST;
            r_r.low_nib <= QCR_CNT_RST;
            r_r.hi <= 1'b1;
            r_r.io_o <= QCR_CNT_RST;
            r_r.io_oe <= QCR_CNT_RST;
            r_r.mem_addr <= QCR_ADDR_RST[QCR_MEM_AW-1:0];
            r_r.mem_rd <= 1'b0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign IO_O = r_r.io_o;
    assign IO_OE_O = r_r.io_oe;
    assign CONTINUOUS_READ_MODE_O = r_r.cont;
    assign MEM_ADDR_O = r_r.mem_addr;
    assign MEM_RD_O = r_r.mem_rd;
endmodule

// ---- verilog/qcr_pkg.sv ----
// constants and carrier types for the quad i/o continuous read block
package qcr_pkg;
    localparam logic [7:0] QCR_OP_QUAD = 8'heb;
    localparam logic [7:0] QCR_OP_ALIGNED = 8'he7;
    localparam logic [3:0] QCR_OPCODE_LAST = 4'h7;
    localparam logic [3:0] QCR_ADDR_LAST = 4'h5;
    localparam logic [3:0] QCR_MODE_LAST = 4'h1;
    localparam logic [3:0] QCR_DUMMY_BASE = 4'h2;
    localparam logic [2:0] QCR_DC_MAX = 3'h4;
    localparam logic [7:0] QCR_MODE_CONT_MASK = 8'h30;
    localparam logic [7:0] QCR_MODE_CONT_VAL = 8'h20;
    localparam int QCR_MEM_AW = 21;
    localparam logic [5:0] QCR_PIN_RST = 6'h20;
    localparam logic [3:0] QCR_CNT_RST = 4'h0;
    localparam logic [7:0] QCR_BYTE_RST = 8'h00;
    localparam logic [23:0] QCR_ADDR_RST = 24'h000000;

    typedef enum logic [5:0] {
        QCR_ST_IDLE   = 6'b000001,
        QCR_ST_OPCODE = 6'b000010,
        QCR_ST_ADDR   = 6'b000100,
        QCR_ST_DUMMY  = 6'b001000,
        QCR_ST_DATA   = 6'b010000,
        QCR_ST_IGNORE = 6'b100000
    } qcr_state_t;

    // synchronised link pins
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic [3:0] io;
    } qcr_pins_t;

    typedef struct packed {
        qcr_state_t st;
        logic sck_q;
        logic [3:0] cnt;
        logic [3:0] dummy_total;
        logic [7:0] opcode;
        logic aligned_cmd;
        logic [23:0] addr;
        logic [7:0] mode;
        logic cont;
        logic [7:0] next_byte;
        logic [3:0] low_nib;
        logic hi;
        logic [3:0] io_o;
        logic [3:0] io_oe;
        logic [QCR_MEM_AW-1:0] mem_addr;
        logic mem_rd;
    } qcr_core_st_t;
endpackage

// ---- verilog/qcr_sync.sv ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module qcr_sync #(
    parameter int WIDTH = 6,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] level_o
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } qcr_sync_st_t;

    qcr_sync_st_t r_r;
    qcr_sync_st_t r_nxt;

    always_comb begin
        r_nxt = r_r;
        r_nxt.s1 = async_i;
        r_nxt.s2 = r_r.s1;
        r_nxt.s3 = r_r.s2;
        // a bit changes only once stages two and three agree
        for (int i = 0; i < WIDTH; i++) begin
            if (r_r.s2[i] == r_r.s3[i]) begin
                r_nxt.lvl[i] = r_r.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            r_r <= r_nxt;
        end
    end

    assign level_o = r_r.lvl;
endmodule
